//--- shared/hta_pkg.sv
// Constants and types shared by the throttle-time and alert-mask block
package hta_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TIMER   = 8'h0f;
    localparam logic [7:0] ADDR_STATUS1 = 8'h10;
    localparam logic [7:0] ADDR_STATUS2 = 8'h11;
    localparam logic [7:0] ADDR_MASK1   = 8'h12;
    localparam logic [7:0] ADDR_MASK2   = 8'h13;
    localparam logic [7:0] ADDR_LIMIT   = 8'h1e;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_TIMER = 8'h00;
    localparam logic [7:0] RST_MASK1 = 8'h00;
    localparam logic [5:0] RST_MASK2 = 6'h00;
    localparam logic [7:0] RST_LIMIT = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // ------------------------------------------------------------
    // Field positions, widths and counter values
    // ------------------------------------------------------------
    localparam int STAT1_SUMMARY_BIT = 7;
    localparam int STAT2_HOT_BIT     = 1;
    localparam int STAT2_WIDTH       = 6;
    localparam logic [7:0] TIMER_FIRST_VALUE = 8'h01;
    localparam logic [7:0] TIMER_STEP_START  = 8'h02;
    localparam logic [7:0] TIMER_FULL_SCALE  = 8'hff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 4;
    localparam int TICK_NS        = 1000;
    localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam int FIRST_TIME_MS  = 50;
    localparam int STEP_TIME_10US = 2276;
    localparam int FIRST_TICKS    = (FIRST_TIME_MS * 1000000) / TICK_NS;
    localparam int STEP_TICKS     = (STEP_TIME_10US * 10000) / TICK_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HTA_IDLE  = 2'b00,
        HTA_FIRST = 2'b01,
        HTA_STEP  = 2'b10
    } hta_state_type;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hta_reg_req_type;

    // Live out-of-limit levels from the measurement logic
    typedef struct packed {
        logic analog_one_or_remote_two;
        logic analog_two_input;
        logic supply_out;
        logic remote_diode_one;
        logic local_sensor;
        logic tach_one_slow;
        logic tach_two_slow;
        logic thermistor_a_fault;
        logic thermistor_b_fault;
        logic diode_one_fault;
        logic diode_two_fault;
        logic critical_temp_trip;
    } hta_cond_type;

endpackage

//--- hdl/hta_tick_div.sv
// Enable-gated divider producing the accumulation tick
`timescale 1ns/1ps
module hta_tick_div (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_en,
    input  wire logic i_clr,
    output logic      o_tick
);
    import hta_pkg::*;

    localparam logic [7:0] LAST = 8'(TICK_CYCLES - 1);

    logic [7:0] cnt;
    wire        wrap = i_en && (cnt == LAST);

    // Phase is held while disabled so paused time is not lost
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt    <= 8'h00;
            o_tick <= 1'b0;
        end else if (i_clr) begin
            cnt    <= 8'h00;
            o_tick <= 1'b0;
        end else begin
            cnt    <= wrap ? 8'h00 : (i_en ? cnt + 8'h01 : cnt);
            o_tick <= wrap;
        end
    end
endmodule

//--- hdl/hta_sticky_flag.sv
// One sticky status flag where a set beats a same-cycle clear
`timescale 1ns/1ps
module hta_sticky_flag (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_set,
    input  wire logic i_clr,
    output logic      o_flag
);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_flag <= 1'b0;
        end else begin
            o_flag <= i_set | (o_flag & ~i_clr);
        end
    end
endmodule

//--- hdl/hta_top.sv
// Throttle-time accumulator, limit compare, sticky status and alert masking
`timescale 1ns/1ps

// Overview of operation
// - Mask gates alert only; status still sets
// - First mask: summary, analog, supply, temps, fans
// - Second mask: thermistor, diode, throttle, critical faults
// - Count only while throttle input asserted
// - Read clears counter; saturate at full scale
// - Bit0 first, then bit1 past 50 ms
// - Counter read clears throttle-limit status flag
// - Read during assertion restarts at one
// - Count above limit sets flag and alert
// - Limit zero first assertion, one after 50ms
// - Limit spans first assertion to seconds
// - Status flags sticky until read when clear
// - Second status bit1 reports limit exceeded
// - First status bit7 summarises second register
module hta_top #(
    parameter logic [15:0] P_FIRST_TICKS = 16'(hta_pkg::FIRST_TICKS),
    parameter logic [15:0] P_STEP_TICKS  = 16'(hta_pkg::STEP_TICKS)
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rstn,
    input  wire logic                     i_processor_hot_n,
    input  wire hta_pkg::hta_cond_type    i_cond,
    input  wire hta_pkg::hta_reg_req_type i_req,
    output logic [7:0]                    o_reg_rdata,
    output logic                          o_reg_ack,
    output logic                          o_alert_n
);
    import hta_pkg::*;

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    wire hit_timer   = (i_req.addr == ADDR_TIMER);
    wire hit_status1 = (i_req.addr == ADDR_STATUS1);
    wire hit_status2 = (i_req.addr == ADDR_STATUS2);
    wire hit_mask1   = (i_req.addr == ADDR_MASK1);
    wire hit_mask2   = (i_req.addr == ADDR_MASK2);
    wire hit_limit   = (i_req.addr == ADDR_LIMIT);

    wire rd_timer   = i_req.rd && hit_timer;
    wire rd_status1 = i_req.rd && hit_status1;
    wire rd_status2 = i_req.rd && hit_status2;
    wire wr_mask1   = i_req.wr && hit_mask1;
    wire wr_mask2   = i_req.wr && hit_mask2;
    wire wr_limit   = i_req.wr && hit_limit;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [7:0] alert_mask_first;
    logic [5:0] alert_mask_second;
    logic [7:0] throttle_time_limit;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            alert_mask_first <= RST_MASK1;
        end else if (wr_mask1) begin
            alert_mask_first <= i_req.wdata;
        end
    end

    // Upper two bits of the second mask are not kept and read zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            alert_mask_second <= RST_MASK2;
        end else if (wr_mask2) begin
            alert_mask_second <= i_req.wdata[5:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            throttle_time_limit <= RST_LIMIT;
        end else if (wr_limit) begin
            throttle_time_limit <= i_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Throttle-time accumulation
    // ------------------------------------------------------------
    // Throttle pin is taken as already synchronous to the clock
    wire           hot_active = ~i_processor_hot_n;
    wire           tick;
    hta_state_type state;
    hta_state_type next_state;
    logic [7:0]    throttle_time_counter;
    logic [7:0]    next_count;
    logic [15:0]   sub_acc;
    logic [15:0]   next_sub_acc;

    // Divider runs only while asserted, so pauses keep partial time
    hta_tick_div u_tick_div (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_en   (hot_active),
        .i_clr  (rd_timer),
        .o_tick (tick)
    );

    wire first_done = (sub_acc == P_FIRST_TICKS - 16'h0001);
    wire step_done  = (sub_acc == P_STEP_TICKS - 16'h0001);
    wire saturated  = (throttle_time_counter == TIMER_FULL_SCALE);

    // ------------------------------------------------------------
    // Measurement sequencing
    // ------------------------------------------------------------
    // A counter read restarts the measurement, divider phase included
    always_comb begin
        next_state   = state;
        next_count   = throttle_time_counter;
        next_sub_acc = sub_acc;
        if (rd_timer) begin
            next_state   = HTA_IDLE;
            next_count   = RST_TIMER;
            next_sub_acc = 16'h0000;
            if (hot_active) begin
                next_state = HTA_FIRST;
                next_count = TIMER_FIRST_VALUE;
            end
        end else begin
            unique case (state)
                HTA_IDLE: begin
                    if (hot_active) begin
                        next_state = HTA_FIRST;
                        next_count = TIMER_FIRST_VALUE;
                    end
                end
                HTA_FIRST: begin
                    if (tick) begin
                        if (first_done) begin
                            next_state   = HTA_STEP;
                            next_count   = TIMER_STEP_START;
                            next_sub_acc = 16'h0000;
                        end else begin
                            next_sub_acc = sub_acc + 16'h0001;
                        end
                    end
                end
                HTA_STEP: begin
                    // Full scale freezes the count until a read
                    if (tick && !saturated) begin
                        if (step_done) begin
                            next_count   = throttle_time_counter + 8'h01;
                            next_sub_acc = 16'h0000;
                        end else begin
                            next_sub_acc = sub_acc + 16'h0001;
                        end
                    end
                end
                default: begin
                    next_state = HTA_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counter state registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= HTA_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            throttle_time_counter <= RST_TIMER;
        end else begin
            throttle_time_counter <= next_count;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sub_acc <= 16'h0000;
        end else begin
            sub_acc <= next_sub_acc;
        end
    end

    // ------------------------------------------------------------
    // Limit compare
    // ------------------------------------------------------------
    // Compare the post-read value so a read clears the flag unless
    // a zero limit re-arms it on an ongoing assertion
    wire hot_exceeded = (next_count > throttle_time_limit);

    // ------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------
    wire [6:0] cond1 = {i_cond.analog_one_or_remote_two,
                        i_cond.analog_two_input,
                        i_cond.supply_out,
                        i_cond.remote_diode_one,
                        i_cond.local_sensor,
                        i_cond.tach_one_slow,
                        i_cond.tach_two_slow};
    wire [5:0] cond2 = {i_cond.thermistor_a_fault,
                        i_cond.thermistor_b_fault,
                        i_cond.diode_one_fault,
                        i_cond.diode_two_fault,
                        hot_exceeded,
                        i_cond.critical_temp_trip};

    logic [6:0] status1_flags;
    logic [5:0] status2_flags;
    logic [5:0] clr2;

    // ------------------------------------------------------------
    // Status clear terms
    // ------------------------------------------------------------
    // Flags clear on a status read only once the cause is gone
    always_comb begin
        clr2 = {STAT2_WIDTH{rd_status2}} & ~cond2;
        clr2[STAT2_HOT_BIT] = rd_timer | (rd_status2 & ~hot_exceeded);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_stat1
            hta_sticky_flag u_flag (
                .i_clk  (i_clk),
                .i_rstn (i_rstn),
                .i_set  (cond1[gi]),
                .i_clr  (rd_status1 & ~cond1[gi]),
                .o_flag (status1_flags[gi])
            );
        end
        for (gi = 0; gi < STAT2_WIDTH; gi++) begin : g_stat2
            hta_sticky_flag u_flag (
                .i_clk  (i_clk),
                .i_rstn (i_rstn),
                .i_set  (cond2[gi]),
                .i_clr  (clr2[gi]),
                .o_flag (status2_flags[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Status register views
    // ------------------------------------------------------------
    // Summary is live, so it drops as soon as the second register clears
    wire       second_status_summary = |status2_flags;
    wire [7:0] status1_view = {second_status_summary, status1_flags};
    wire [7:0] status2_view = {2'b00, status2_flags};

    // ------------------------------------------------------------
    // Alert generation
    // ------------------------------------------------------------
    // Masks gate only the pin; flags above are set regardless
    wire [6:0] live1 = status1_flags & ~alert_mask_first[6:0];
    wire [5:0] live2 = status2_flags & ~alert_mask_second;
    wire       gate2 = ~alert_mask_first[STAT1_SUMMARY_BIT];
    wire       any_live = (|live1) | (gate2 & (|live2));

    // Pin comes from a flop so it cannot glitch while flags settle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_alert_n <= 1'b1;
        end else begin
            o_alert_n <= ~any_live;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped reads return zero rather than a stale byte
    wire [7:0] rd_mux =
        hit_timer   ? throttle_time_counter :
        hit_status1 ? status1_view :
        hit_status2 ? status2_view :
        hit_mask1   ? alert_mask_first :
        hit_mask2   ? {2'b00, alert_mask_second} :
        hit_limit   ? throttle_time_limit :
                      RST_RDATA;

    // Every access is answered, mapped or not, so the host never stalls
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_ack <= 1'b0;
        end else begin
            o_reg_ack <= i_req.rd | i_req.wr;
        end
    end

    // Data holds between reads so a slow host can still pick it up
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= RST_RDATA;
        end else if (i_req.rd) begin
            o_reg_rdata <= rd_mux;
        end
    end

endmodule

//--- bench/hta_top_monitor.sv
// Port-level checks for the throttle-time and alert-mask block
`timescale 1ns/1ps
module hta_top_monitor (
    input wire logic                     i_clk,
    input wire logic                     i_rstn,
    input wire logic                     i_processor_hot_n,
    input wire hta_pkg::hta_cond_type    i_cond,
    input wire hta_pkg::hta_reg_req_type i_req,
    input wire logic [7:0]               o_reg_rdata,
    input wire logic                     o_reg_ack,
    input wire logic                     o_alert_n
);
    import hta_pkg::*;
    // ----
    // Shadow of the writable registers
    // ----
    logic [7:0] m1;
    logic [5:0] m2;
    logic [7:0] lim;
    wire logic  hot = !i_processor_hot_n;
    wire logic  rd_t = i_req.rd && (i_req.addr == ADDR_TIMER);
    wire logic  rd_s2 = i_req.rd && (i_req.addr == ADDR_STATUS2);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            m1 <= 8'h00;
            m2 <= 6'h00;
            lim <= 8'h00;
        end else if (i_req.wr) begin
            if (i_req.addr == ADDR_MASK1) m1 <= i_req.wdata;
            if (i_req.addr == ADDR_MASK2) m2 <= i_req.wdata[5:0];
            if (i_req.addr == ADDR_LIMIT) lim <= i_req.wdata;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ----
    // Properties
    // ----
    property p_ack; (i_req.rd || i_req.wr) |=> o_reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_mask1; (i_req.rd && i_req.addr == ADDR_MASK1) |=> o_reg_rdata == $past(m1);
    endproperty
    a_mask1: assert property (p_mask1) else $error("mask one readback");
    property p_mask2;
        (i_req.rd && i_req.addr == ADDR_MASK2) |=> o_reg_rdata == {2'h0, $past(m2)};
    endproperty
    a_mask2: assert property (p_mask2) else $error("mask two readback");
    property p_limit; (i_req.rd && i_req.addr == ADDR_LIMIT) |=> o_reg_rdata == $past(lim);
    endproperty
    a_limit: assert property (p_limit) else $error("limit readback");
    property p_first; (hot && lim == 8'h00 && !m2[1] && !m1[7]) |-> ##[1:3] !o_alert_n;
    endproperty
    a_first: assert property (p_first) else $error("no alert on first assertion");
    property p_clr; (rd_t && !hot) ##1 !hot ##1 (rd_t && !hot) |=> o_reg_rdata == 8'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("timer not cleared by read");
    property p_hclr; (rd_t && !hot) ##1 !hot ##1 (rd_s2 && !hot) |=> !o_reg_rdata[1];
    endproperty
    a_hclr: assert property (p_hclr) else $error("limit flag kept after read");
    property p_all; (m1 == 8'hff && m2 == 6'h3f) [*3] |-> o_alert_n; endproperty
    a_all: assert property (p_all) else $error("alert while all masked");
    property p_cond; (i_cond.local_sensor && !m1[2]) |-> ##[1:3] !o_alert_n; endproperty
    a_cond: assert property (p_cond) else $error("unmasked flag gave no alert");
    c_rd: cover property (rd_t ##1 o_reg_ack);
    c_hot: cover property (hot ##1 !hot);
    c_alert: cover property ($fell(o_alert_n));
endmodule
bind hta_top hta_top_monitor u_hta_top_monitor (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_processor_hot_n(i_processor_hot_n), .i_cond(i_cond), .i_req(i_req),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_alert_n(o_alert_n));

//--- bench/hta_hot_src.sv
// Processor throttle source holding the hot input low for a set count
`timescale 1ns/1ps
module hta_hot_src (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_go,
    input  wire logic [16:0] i_len,
    output logic             o_processor_hot_n
);
    logic [16:0] left;
    assign o_processor_hot_n = (left == 17'h0);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            left <= 17'h0;
        end else if (i_go) begin
            left <= i_len;
        end else if (left != 17'h0) begin
            left <= left - 17'h1;
        end
    end
endmodule

//--- bench/hta_top_tb.sv
// Self-checking bench for the throttle-time and alert-mask block
`timescale 1ns/1ps
module hta_top_tb;
    import hta_pkg::*;
    logic            i_clk;
    logic            i_rstn;
    logic            hot_n;
    logic            go;
    logic [16:0]     len;
    hta_cond_type    i_cond;
    hta_reg_req_type req;
    logic [7:0]      o_reg_rdata;
    logic            o_reg_ack;
    logic            o_alert_n;
    logic [8:0]      exp_q[$];
    int              num_errors = 0;
    int              compares = 0;
    int              cyc = 0;
    int              seed = 32'hadd7;
    hta_top #(.P_FIRST_TICKS(16'h0002), .P_STEP_TICKS(16'h0001)) u_hta_top (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_processor_hot_n(hot_n), .i_cond(i_cond),
        .i_req(req), .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
        .o_alert_n(o_alert_n));
    hta_hot_src u_hta_hot_src (.i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_len(len),
        .o_processor_hot_n(hot_n));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        compares++;
        if (a !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask
    task automatic print_verdict();
        if (exp_q.size() != 0) num_errors++;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic rq(input logic r, input logic [7:0] a, d, input logic [8:0] e);
        @(posedge i_clk);
        req <= {r, !r, a, d};
        exp_q.push_back(e);
        @(posedge i_clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        rq(1'b1, a, 8'h00, {1'b1, e});
    endtask
    task automatic wr(input logic [7:0] a, d);
        rq(1'b0, a, d, 9'h000);
    endtask
    task automatic al(input logic e);
        @(posedge i_clk);
        #1 chk({7'h0, o_alert_n}, {7'h0, e});
    endtask
    task automatic hot(input int n, input logic wt);
        @(posedge i_clk);
        go <= 1'b1;
        len <= 17'(n);
        @(posedge i_clk);
        go <= 1'b0;
        if (wt) w(n + 3);
    endtask
    // Results are matched in request order, one note per ack, mid-cycle
    always @(negedge i_clk) begin
        cyc++;
        if (cyc == 80000) begin
            num_errors++;
            print_verdict();
        end else if (o_reg_ack === 1'b1) begin
            if (exp_q.size() == 0) chk(8'h01, 8'h00);
            else if (exp_q[0][8]) chk(o_reg_rdata, exp_q.pop_front());
            else void'(exp_q.pop_front());
        end
    end
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        logic [7:0]  ra [7];
        logic [31:0] r;
        logic        s1;
        int          b;
        logic [7:0]  bv;
        ra = '{ADDR_TIMER, ADDR_STATUS1, ADDR_STATUS2, ADDR_MASK1, ADDR_MASK2, ADDR_LIMIT, 8'h30};
        i_rstn = 1'b0;
        req = '0;
        i_cond = '0;
        go = 1'b0;
        len = 17'h0;
        w(10);
        i_rstn <= 1'b1;
        foreach (ra[k]) rd(ra[k], 8'h00);
        wr(ADDR_MASK1, 8'hff);
        wr(ADDR_MASK2, 8'hff);
        rd(ADDR_MASK2, 8'h3f);
        @(posedge i_clk) i_cond <= '1;
        @(posedge i_clk) i_cond <= '0;
        w(3);
        al(1'b1);
        rd(ADDR_STATUS1, 8'hff);
        rd(ADDR_STATUS2, 8'h3d);
        rd(ADDR_STATUS1, 8'h00);
        r = $random(seed);
        wr(ADDR_MASK1, r[7:0]);
        rd(ADDR_MASK1, r[7:0]);
        wr(ADDR_LIMIT, r[15:8]);
        rd(ADDR_LIMIT, r[15:8]);
        wr(ADDR_TIMER, 8'h55);
        rd(ADDR_TIMER, 8'h00);
        wr(ADDR_MASK1, 8'h00);
        wr(ADDR_LIMIT, 8'h00);
        for (int i = 0; i < 12; i++) begin
            for (int m = 0; m < 2; m++) begin
                s1 = (i >= 5);
                b = s1 ? i - 5 : (i == 0 ? 0 : i + 1);
                bv = 8'h01 << b;
                wr(s1 ? ADDR_MASK1 : ADDR_MASK2, m[0] ? bv : 8'h00);
                @(posedge i_clk) i_cond <= hta_cond_type'(12'h001 << i);
                w(3);
                al(m[0]);
                rd(s1 ? ADDR_STATUS1 : ADDR_STATUS2, bv);
                i_cond <= '0;
                al(m[0]);
                rd(s1 ? ADDR_STATUS1 : ADDR_STATUS2, bv);
                rd(s1 ? ADDR_STATUS1 : ADDR_STATUS2, 8'h00);
                w(2);
                al(1'b1);
            end
        end
        hot(1, 1'b1);
        al(1'b0);
        rd(ADDR_STATUS2, 8'h02);
        rd(ADDR_STATUS1, 8'h80);
        wr(ADDR_MASK2, 8'h02);
        al(1'b1);
        rd(ADDR_TIMER, 8'h01);
        rd(ADDR_TIMER, 8'h00);
        rd(ADDR_STATUS2, 8'h00);
        wr(ADDR_MASK2, 8'h00);
        hot(200, 1'b0);
        w(20);
        rd(ADDR_TIMER, 8'h01);
        rd(ADDR_STATUS2, 8'h02);
        w(200);
        rd(ADDR_TIMER, 8'h01);
        rd(ADDR_STATUS2, 8'h00);
        wr(ADDR_LIMIT, 8'h01);
        hot(300, 1'b1);
        rd(ADDR_STATUS2, 8'h00);
        hot(300, 1'b1);
        al(1'b0);
        rd(ADDR_STATUS2, 8'h02);
        rd(ADDR_TIMER, 8'h02);
        wr(ADDR_LIMIT, 8'hfe);
        hot(64000, 1'b1);
        al(1'b0);
        rd(ADDR_TIMER, 8'hff);
        w(4);
        print_verdict();
    end
endmodule
